/* logic/lamp_consts.svh */
// Constant definitions for the lamp switch serial configuration block
`ifndef LAMP_CONSTS_SVH
`define LAMP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS       16
`define FRAME_WD_BIT     15
`define FRAME_ADDR_HI    14
`define FRAME_OUT_BIT    13
`define FRAME_ADDR_LO_MSB 12
`define FRAME_ADDR_LO_LSB 10
`define FRAME_PAY_MSB    8

// ----------------------------------------------------------------------------
// Register addresses as {D14, D12:D10}
// ----------------------------------------------------------------------------
`define ADDR_STATUS_LOW  3'h0
`define ADDR_DUTY        4'h9
`define ADDR_SWITCH      4'ha
`define ADDR_FAULT       4'hb
`define ADDR_OVERCUR     4'hc
`define ADDR_GLOBAL      4'h5
`define ADDR_CALIB       4'h7

// ----------------------------------------------------------------------------
// Reply select codes
// ----------------------------------------------------------------------------
`define CODE_PER_OUT_BIT 4
`define CODE_OUT_BIT     3
`define CODE_FAULT_LOW   3'h0
`define CODE_DUTY_LOW    3'h1
`define CODE_SWITCH_LOW  3'h2
`define CODE_FAULT_CFG_LOW 3'h3
`define CODE_OVERCUR_LOW 3'h4
`define CODE_GLOBAL      5'h05
`define REPLY_NM_BIT     9

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GC_SUPPLY_FAIL   8
`define GC_DUTY_EN       7
`define GC_CLK_INT       6
`define GC_TEMP          5
`define GC_CURRENT       4
`define GC_OUT_HI        3
`define GC_OUT_LO        2
`define GC_OV_OFF        0
`define SW_DIRECT_OFF    5
`define SW_SLEW_LSB      3
`define SW_DELAY_LSB     0
`define FT_RETRY_UNL     6
`define FT_RETRY_OFF     5
`define FT_SHORT_OFF     4
`define FT_ONOL_OFF      3
`define FT_OFFOL_OFF     2
`define FT_LED           1
`define FT_RATIO         0
`define OC_GAS_OFF       8
`define OC_COOL_LSB      6
`define OC_INRUSH_LSB    4
`define OC_BOOST         3
`define OC_STEADY_LSB    1
`define OC_MODE          0
`define DT_ON            7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define REG_RESET        9'h000
`define POR_FLAG_RESET   1'b1

`endif

/* logic/lamp_pkg.sv */
// Types shared by the lamp switch serial configuration block
`default_nettype none
package lamp_pkg;
  typedef enum logic [1:0] {
    SENSE_OFF     = 2'b00,
    SENSE_TEMP    = 2'b01,
    SENSE_CURRENT = 2'b11
  } sense_mode_t;
  typedef logic [8:0]  payload_t;
  typedef logic [15:0] frame_t;
endpackage : lamp_pkg
`default_nettype wire

/* logic/pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clock domain
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0  // Idle level of each pin
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      // Idle levels, so no false edge appears when reset lifts
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* logic/output_drive.sv */
// Switch command selection for one high-side output
`default_nettype none
module output_drive (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic duty_en_i,
  input  wire logic failsafe_i,
  input  wire logic direct_off_i,
  input  wire logic on_bit_i,
  input  wire logic direct_in_i,
  input  wire logic duty_wave_i,
  output logic      switch_on_o
);
  logic duty_mode;

  // Duty engine owns the output when enabled or in fail-safe
  assign duty_mode = duty_en_i | failsafe_i; // R14 R15

  // Registered so the gate driver never sees a decode glitch
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      switch_on_o <= 1'b0;
    end else if (duty_mode) begin
      switch_on_o <= duty_wave_i; // R15
    end else if (direct_off_i) begin
      switch_on_o <= on_bit_i; // R1
    end else begin
      switch_on_o <= on_bit_i | direct_in_i; // R1
    end
  end

  a_duty_owns: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    duty_en_i |=> switch_on_o == $past(duty_wave_i)) // R15
    else $error("duty mode output not following duty wave");
  a_failsafe_duty: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    failsafe_i && !duty_en_i |=> switch_on_o == $past(duty_wave_i)) // R14
    else $error("fail-safe output not following duty wave");
  a_direct_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !duty_mode && direct_off_i |=> switch_on_o == $past(on_bit_i)) // R1
    else $error("direct input reached output while disabled");
endmodule : output_drive
`default_nettype wire

/* logic/lamp_switch_spi_config.sv */
// Serial configuration and status return logic of a dual-output lamp switch
//
// Overview of operation
// R1 - Direct pin drives output unless direct-disable set; then only on-bit drives it.
// R2 - Two-bit slew field: 00 medium, 01 low, 10 high; 11 unused.
// R3 - Three-bit delay field in duty clock edges, effective only with duty module on.
// R4 - Unlimited-retry removes retry time limit; retry-disable turns retry off.
// R5 - Short-to-battery-disable bit turns off hard short-to-supply protection.
// R6 - On open-load disable, LED or bulb threshold select, off open-load disable.
// R7 - Sense-ratio bit picks high ratio when 1, low ratio when 0.
// R8 - Gas-discharge bit set to 1 disables the special lamp overcurrent profile.
// R9 - Cooling field: 00 medium, 01 slow, 10 fast, 11 medium.
// R10 - Inrush field: 00 slow, 01 fast, 10 medium, 11 very slow.
// R11 - Boost bit swaps in second upper limit during first overcurrent window.
// R12 - Steady limit field: 00 level two, 01 three, 10 four, 11 one.
// R13 - Overcurrent mode: 0 inrush only, 1 inrush with bulb cooling.
// R14 - Supply-fail enable plus low supply keeps outputs on duty registers.
// R15 - Duty module enable drives both outputs from duty registers, ignoring pins.
// R16 - Clock source bit picks external or internal clock, only when duty enabled.
// R17 - Feedback bits choose off, temperature, or current of selected output.
// R18 - Overvoltage protection active while its disable bit is 0.
// R19 - Chip select fall loads reply; shifted out MSB first while receiving.
// R20 - After sixteen reply bits, serial output repeats bits received this frame.
// R21 - Latch only frames of multiples of sixteen bits; output tri-states.
// R22 - Reply selection changes only on a new status-select write.
// R23 - Frame: bit 15 watchdog, 14 and 12-10 address, 13 output, 8-0 payload.
// R24 - Reply bit 15 echoes watchdog bit, bits 14-10 echo the select code.
// R25 - Reset clears all programmable bits and sets the power-on flag.
`default_nettype none
`include "lamp_consts.svh"
module lamp_switch_spi_config
  import lamp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oe_o,
  input  wire logic [1:0]  direct_in_i,
  input  wire logic [1:0]  duty_wave_i,
  input  wire logic        supply_low_i,
  input  wire logic [15:0] fault_flags_i,
  output logic [1:0]       switch_on_o,
  output logic [13:0]      duty_level_o,
  output logic [3:0]       slew_select_o,
  output logic [5:0]       delay_select_o,
  output logic [1:0]       retry_unlimited_o,
  output logic [1:0]       retry_off_o,
  output logic [1:0]       short_to_battery_off_o,
  output logic [1:0]       on_openload_off_o,
  output logic [1:0]       off_openload_off_o,
  output logic [1:0]       led_threshold_select_o,
  output logic [1:0]       sense_ratio_select_o,
  output logic [1:0]       gas_profile_off_o,
  output logic [3:0]       cooling_curve_o,
  output logic [3:0]       inrush_curve_o,
  output logic [1:0]       high_level_boost_o,
  output logic [3:0]       steady_limit_o,
  output logic [1:0]       overcurrent_mode_select_o,
  output logic             duty_enable_o,
  output logic             clock_internal_o,
  output var sense_mode_t  sense_mode_o,
  output logic             sense_output_one_o,
  output logic             overvoltage_protect_off_o,
  output logic             failsafe_active_o,
  output logic [8:0]       calibration_o,
  output logic             calibration_strobe_o
);

  // --------------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------------
  logic       cs_n_s;
  logic       sclk_s;
  logic       si_s;
  logic [1:0] direct_s;
  logic       supply_low_s;
  logic       cs_n_d;
  logic       sclk_d;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;

  // All serial pins share one synchroniser so their skew stays equal
  // Select resets high, its idle level, so reset never fakes a frame
  pin_sync #(
    .WIDTH    (6),
    .RESET_VAL(6'h01)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i  (rst_n_i),
    .async_i  ({supply_low_i, direct_in_i, si_i, sclk_i, chip_select_n_i}),
    .sync_o   ({supply_low_s, direct_s, si_s, sclk_s, cs_n_s})
  );

  // Delayed copies for edge finding; select idles high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  // Clock edges only count inside a frame
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  assign cs_fall   = ~cs_n_s & cs_n_d;
  assign cs_rise   = cs_n_s & ~cs_n_d;

  // --------------------------------------------------------------------------
  // Receive side
  // --------------------------------------------------------------------------
  frame_t     rx_shift;
  logic [3:0] bit_cnt;
  logic       frame_any;
  logic       si_held;
  logic       latch;
  logic [3:0] addr;
  logic       sel;
  payload_t   pay;

  // Bits sampled on the rising serial clock edge, MSB first
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_shift <= '0;
      si_held  <= 1'b0;
    end else if (sclk_rise) begin
      rx_shift <= {rx_shift[14:0], si_s}; // R23
      si_held  <= si_s;
    end
  end

  // Count modulo sixteen; counter wraps so any multiple passes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bit_cnt   <= 4'h0;
      frame_any <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt   <= 4'h0;
      frame_any <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt   <= bit_cnt + 4'h1;
      frame_any <= 1'b1;
    end
  end

  // Last sixteen bits hold this device's frame in a daisy chain
  assign latch = cs_rise & frame_any & (bit_cnt == 4'h0); // R21
  assign addr  = {rx_shift[`FRAME_ADDR_HI], rx_shift[`FRAME_ADDR_LO_MSB:`FRAME_ADDR_LO_LSB]}; // R23
  assign sel   = rx_shift[`FRAME_OUT_BIT];
  assign pay   = rx_shift[`FRAME_PAY_MSB:0];

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [1:0][7:0] duty_reg;
  logic [1:0][5:0] switch_reg;
  logic [1:0][6:0] fault_reg;
  logic [1:0][8:0] overcur_reg;
  payload_t        global_config;
  payload_t        oscillator_calibration;

  // Per-output writes steered by the output select bit
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      duty_reg    <= '0; // R25
      switch_reg  <= '0; // R25
      fault_reg   <= '0; // R25
      overcur_reg <= '0; // R25
    end else if (latch) begin
      unique case (addr)
        `ADDR_DUTY:    duty_reg[sel]    <= pay[7:0];
        `ADDR_SWITCH:  switch_reg[sel]  <= pay[5:0];
        `ADDR_FAULT:   fault_reg[sel]   <= pay[6:0];
        `ADDR_OVERCUR: overcur_reg[sel] <= pay;
        default: ;
      endcase
    end
  end

  // Global settings; the unused bit 1 is never stored
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      global_config <= `REG_RESET; // R25
    end else if (latch && addr == `ADDR_GLOBAL) begin
      global_config <= pay & 9'h1fd;
    end
  end

  // Calibration word is write-only and handed on with a strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      oscillator_calibration <= `REG_RESET;
      calibration_strobe_o   <= 1'b0;
    end else begin
      calibration_strobe_o <= latch && addr == `ADDR_CALIB;
      if (latch && addr == `ADDR_CALIB) begin
        oscillator_calibration <= pay;
      end
    end
  end

  assign calibration_o = oscillator_calibration;

  // --------------------------------------------------------------------------
  // Reply selection and echo state
  // --------------------------------------------------------------------------
  logic [4:0] reply_sel;
  logic       prev_wd;
  logic       por_flag;
  logic       fault_read;

  // Select code only moves on a status-select write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reply_sel <= 5'h00;
    end else if (latch && addr[2:0] == `ADDR_STATUS_LOW) begin
      reply_sel <= pay[4:0]; // R22
    end
  end

  // Watchdog bit of the last valid frame is echoed next time
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev_wd <= 1'b0;
    end else if (latch) begin
      prev_wd <= rx_shift[`FRAME_WD_BIT]; // R24
    end
  end

  // Power-on flag survives until a fault report is delivered validly
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      por_flag   <= `POR_FLAG_RESET;
      fault_read <= 1'b0;
    end else begin
      if (cs_fall) begin
        fault_read <= reply_sel[`CODE_PER_OUT_BIT] && reply_sel[2:0] == `CODE_FAULT_LOW;
      end
      if (latch && fault_read) begin
        por_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Reply composition
  // --------------------------------------------------------------------------
  payload_t reply_pay;
  frame_t   reply;
  logic     ro;

  assign ro = reply_sel[`CODE_OUT_BIT];

  // Unknown codes answer zero rather than stale data
  always_comb begin
    reply_pay = 9'h000;
    if (reply_sel[`CODE_PER_OUT_BIT]) begin
      unique case (reply_sel[2:0])
        `CODE_FAULT_LOW:     reply_pay = {por_flag, fault_flags_i[ro*8 +: 8]};
        `CODE_DUTY_LOW:      reply_pay = {1'b0, duty_reg[ro]};
        `CODE_SWITCH_LOW:    reply_pay = {3'b000, switch_reg[ro]};
        `CODE_FAULT_CFG_LOW: reply_pay = {2'b00, fault_reg[ro]};
        `CODE_OVERCUR_LOW:   reply_pay = overcur_reg[ro];
        default:             reply_pay = 9'h000;
      endcase
    end else if (reply_sel == `CODE_GLOBAL) begin
      reply_pay = global_config;
    end
  end

  // Header echoes previous frame, normal-mode bit set
  assign reply = {prev_wd, reply_sel, 1'b1, reply_pay}; // R24

  // --------------------------------------------------------------------------
  // Transmit side
  // --------------------------------------------------------------------------
  frame_t tx_shift;

  // Loaded on select fall, then refilled with received bits for chaining
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_shift <= '0;
    end else if (cs_fall) begin
      tx_shift <= reply; // R19
    end else if (sclk_fall) begin
      tx_shift <= {tx_shift[14:0], si_held}; // R20
    end
  end

  // Driven only while selected; released as select rises
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= ~cs_n_s; // R21
    end
  end

  assign so_o = tx_shift[15]; // R19

  // --------------------------------------------------------------------------
  // Global decode
  // --------------------------------------------------------------------------
  logic duty_en;
  logic failsafe;

  assign duty_en                   = global_config[`GC_DUTY_EN]; // R15
  assign failsafe                  = global_config[`GC_SUPPLY_FAIL] & supply_low_s; // R14
  assign duty_enable_o             = duty_en;
  assign failsafe_active_o         = failsafe;
  // Source choice is meaningless with the engine off, so report external
  assign clock_internal_o          = duty_en & global_config[`GC_CLK_INT]; // R16
  assign overvoltage_protect_off_o = global_config[`GC_OV_OFF]; // R18
  assign sense_output_one_o        = global_config[`GC_OUT_HI] & global_config[`GC_OUT_LO]; // R17

  // Current feedback outranks temperature
  always_comb begin
    if (global_config[`GC_CURRENT]) begin
      sense_mode_o = SENSE_CURRENT; // R17
    end else if (global_config[`GC_TEMP]) begin
      sense_mode_o = SENSE_TEMP; // R17
    end else begin
      sense_mode_o = SENSE_OFF; // R17
    end
  end

  // --------------------------------------------------------------------------
  // Per-output field decode and drive
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign duty_level_o[g*7 +: 7]         = duty_reg[g][6:0];
    assign slew_select_o[g*2 +: 2]        = switch_reg[g][`SW_SLEW_LSB +: 2]; // R2
    assign delay_select_o[g*3 +: 3]       = duty_en ? switch_reg[g][`SW_DELAY_LSB +: 3] : 3'h0; // R3
    assign retry_unlimited_o[g]           = fault_reg[g][`FT_RETRY_UNL]; // R4
    assign retry_off_o[g]                 = fault_reg[g][`FT_RETRY_OFF]; // R4
    assign short_to_battery_off_o[g]      = fault_reg[g][`FT_SHORT_OFF]; // R5
    assign on_openload_off_o[g]           = fault_reg[g][`FT_ONOL_OFF]; // R6
    assign off_openload_off_o[g]          = fault_reg[g][`FT_OFFOL_OFF]; // R6
    assign led_threshold_select_o[g]      = fault_reg[g][`FT_LED]; // R6
    assign sense_ratio_select_o[g]        = fault_reg[g][`FT_RATIO]; // R7
    assign gas_profile_off_o[g]           = overcur_reg[g][`OC_GAS_OFF]; // R8
    assign cooling_curve_o[g*2 +: 2]      = overcur_reg[g][`OC_COOL_LSB +: 2]; // R9
    assign inrush_curve_o[g*2 +: 2]       = overcur_reg[g][`OC_INRUSH_LSB +: 2]; // R10
    assign high_level_boost_o[g]          = overcur_reg[g][`OC_BOOST]; // R11
    assign steady_limit_o[g*2 +: 2]       = overcur_reg[g][`OC_STEADY_LSB +: 2]; // R12
    assign overcurrent_mode_select_o[g]   = overcur_reg[g][`OC_MODE]; // R13

    output_drive u_drive (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .duty_en_i   (duty_en),
      .failsafe_i  (failsafe),
      .direct_off_i(switch_reg[g][`SW_DIRECT_OFF]),
      .on_bit_i    (duty_reg[g][`DT_ON]),
      .direct_in_i (direct_s[g]),
      .duty_wave_i (duty_wave_i[g]),
      .switch_on_o (switch_on_o[g])
    );
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_reply_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R19
    cs_fall |=> tx_shift == $past(reply))
    else $error("reply not loaded at select fall");
  a_so_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R21
    cs_rise |=> !so_oe_o)
    else $error("serial output still driven after select rise");
  a_bad_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R21
    cs_rise && bit_cnt != 4'h0 |=> $stable(global_config) && $stable(switch_reg) && $stable(reply_sel))
    else $error("short frame changed a register");
  a_select_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R22
    !(latch && addr[2:0] == `ADDR_STATUS_LOW) |=> $stable(reply_sel))
    else $error("reply select moved without a status write");
  a_wd_echo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R24
    latch |=> reply[15] == $past(rx_shift[15]))
    else $error("watchdog echo wrong");
  a_daisy_echo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R20
    sclk_fall && bit_cnt == 4'h0 && frame_any |=> tx_shift == $past(rx_shift))
    else $error("chained bits not repeated after sixteen");
  a_delay_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R3
    !duty_en |-> delay_select_o == 6'h00)
    else $error("delay active with duty module off");
  a_sense_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R17
    global_config[5:4] == 2'b00 |-> sense_mode_o == SENSE_OFF)
    else $error("feedback pin not idle");
  a_global_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R18
    latch && addr == `ADDR_GLOBAL |=> overvoltage_protect_off_o == $past(pay[0]))
    else $error("overvoltage disable not taken from write");

endmodule : lamp_switch_spi_config
`default_nettype wire

/* dv/spi_host_model.sv */
// Serial host model driving frames into the lamp switch block
`default_nettype none
module spi_host_model (
  output logic      chip_select_n_o,
  output logic      sclk_o,
  output logic      si_o,
  input  wire logic so_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // Mode 0 frame, MSB first; clock idles low between frames
  task automatic xfer(input logic [31:0] data, input int n, output logic [31:0] rx);
    rx = '0;
    chip_select_n_o = 1'b0;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = data[i];
      #62.5 sclk_o = 1'b1;
      rx = {rx[30:0], so_i};
      #62.5 sclk_o = 1'b0;
    end
    #62.5 chip_select_n_o = 1'b1;
    si_o = ~si_o; // Released line must not show a stale bit
    #250;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* dv/lamp_switch_spi_config_test.sv */
// Self-checking bench for the lamp switch serial configuration block
`default_nettype none
module lamp_switch_spi_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  import lamp_pkg::*;
  typedef struct packed {logic [3:0] adr; logic a; logic [8:0] pay; logic [4:0] code; logic [8:0] exp;} row_t;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, supply_low = 1'b0, wd = 1'b0;
  logic cs_n, sclk, si, so, so_oe, duty_en, fail, ov_off, clk_int;
  logic [1:0] duty_wave = 2'b10, dir_in = 2'b00, sw_on;
  logic [5:0] dly;
  wire [13:0] flt;
  wire [11:0] crv;
  wire [5:0] ocb;
  logic [3:0] slew;
  logic [15:0] r;
  logic [31:0] rx;
  sense_mode_t sense;
  int err_total = 0, comparisons = 0, cycles = 0;
  // Write, select, then read back through the reply
  row_t rows [5] = '{'{4'ha, 1'b0, 9'h02b, 5'h12, 9'h02b},
    '{4'hb, 1'b1, 9'h07f, 5'h1b, 9'h07f},
    '{4'hc, 1'b0, 9'h1ff, 5'h14, 9'h1ff},
    '{4'h9, 1'b1, 9'h0c5, 5'h19, 9'h0c5},
    '{4'h5, 1'b0, 9'h1f1, 5'h05, 9'h1f1}};
  spi_host_model host (.chip_select_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));
  lamp_switch_spi_config dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n), .sclk_i(sclk),
    .si_i(si), .so_o(so), .so_oe_o(so_oe), .direct_in_i(dir_in), .duty_wave_i(duty_wave),
    .supply_low_i(supply_low), .fault_flags_i(16'ha53c), .switch_on_o(sw_on), .duty_level_o(),
    .slew_select_o(slew), .delay_select_o(dly), .retry_unlimited_o(flt[13:12]), .retry_off_o(flt[11:10]),
    .short_to_battery_off_o(flt[9:8]), .on_openload_off_o(flt[7:6]), .off_openload_off_o(flt[5:4]),
    .led_threshold_select_o(flt[3:2]), .sense_ratio_select_o(flt[1:0]), .gas_profile_off_o(ocb[5:4]),
    .cooling_curve_o(crv[11:8]), .inrush_curve_o(crv[7:4]), .high_level_boost_o(ocb[3:2]),
    .steady_limit_o(crv[3:0]), .overcurrent_mode_select_o(ocb[1:0]), .duty_enable_o(duty_en),
    .clock_internal_o(clk_int), .sense_mode_o(sense),
    .sense_output_one_o(), .overvoltage_protect_off_o(ov_off), .failsafe_active_o(fail),
    .calibration_o(), .calibration_strobe_o());
  always #2.5 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [3:0] adr, input logic a, input logic [8:0] pay, output logic [15:0] q);
    logic [31:0] got;
    wd = ~wd;
    host.xfer({16'h0, wd, adr[3], a, adr[2:0], 1'b0, pay}, 16, got);
    q = got[15:0];
  endtask : send
  task automatic conclude();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Hang guard, well above the expected run length
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    supply_low = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    foreach (rows[k]) begin
      send(rows[k].adr, rows[k].a, rows[k].pay, r);
      send(4'h0, 1'b0, {4'h0, rows[k].code}, r);
      send(4'h0, 1'b0, {4'h0, rows[k].code}, r);
      check(r, {~wd, rows[k].code, 1'b1, rows[k].exp});
    end
    check(slew, 4'h1);
    check(duty_en, 1'b1);
    check(sw_on, duty_wave);
    check(fail, 1'b1);
    check(sense, SENSE_CURRENT);
    check(ov_off, 1'b1);
    // Field decode of the rows above
    check(dly, 6'h03);
    check(clk_int, 1'b1);
    check(flt, 14'h2aaa);
    check(ocb, 6'h15);
    check(crv, 12'h333);
    // Seventeen bits ending in a switch write must be ignored
    host.xfer(32'h0000_4800, 17, rx);
    check(so_oe, 1'b0);
    send(4'h0, 1'b0, 9'h012, r);
    send(4'h0, 1'b0, 9'h012, r);
    check(r[8:0], 9'h02b);
    // Double frame: second half of the reply repeats the first input word
    host.xfer(32'h1234_0012, 32, rx);
    check(rx[25], 1'b1);
    check(rx[15:0], 16'h1234);
    // Mid-run reset with the direct pins already high
    @(posedge ref_clk_i);
    #1 rst_n_i = 1'b0;
    dir_in = 2'b11;
    repeat (3) @(posedge ref_clk_i);
    #1 check({slew, duty_en, sw_on, so_oe, ov_off, fail}, 10'h000);
    rst_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 check(sw_on, 2'b11);
    // Fault report after reset carries the power-on flag once
    send(4'h0, 1'b0, 9'h010, r);
    send(4'h0, 1'b0, 9'h010, r);
    check(r, {~wd, 5'h10, 1'b1, 9'h13c});
    // Direct pin blocked on output zero; report keeps its selection
    send(4'ha, 1'b0, 9'h020, r);
    check(r, {~wd, 5'h10, 1'b1, 9'h03c});
    check(sw_on, 2'b10);
    // Fail-safe alone hands both outputs to the duty waveform
    @(posedge ref_clk_i);
    #1 duty_wave = 2'b01;
    send(4'h5, 1'b0, 9'h100, r);
    check({fail, duty_en, sw_on}, 4'h9);
    conclude();
  end
endmodule : lamp_switch_spi_config_test
`default_nettype wire
